// >>> design/power_mode_controller.sv
// Always-on power mode controller: mode FSM, clock gating, key-guarded mode register
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - four modes, active through hibernate
// - active-mode sleep leaves unit active
// - any wake returns to active
// - mode 1 gates core clock after sleep
// - mode 1 keeps buses for DMA
// - mode 1 keeps interrupt controller clock
// - mode 2 gates system and peripheral buses
// - mode 2 forces peripheral clocks off
// - mode 2 keeps interrupt controller clock
// - hibernate cuts logic power, retains state
// - hibernate wakes only from fixed sources
// - handler entry needs higher priority wake
// - debug hold blocks entry, power-on clear
// - key register guards mode register
// - mode encoding, read returns last write
// - two key words unlock mode write
// - other write relocks the key
module power_mode_controller #(
  parameter int                 N_PERIPH      = 5,
  parameter int                 N_WAKE        = 4,
  parameter int                 PRIO_W        = 8,
  parameter logic [N_WAKE-1:0]  HIB_WAKE_MASK = '1
) (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        sys_rst,
  input  wire logic [pwr_pkg::ADDR_W-1:0]  addr,
  input  wire logic [pwr_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [pwr_pkg::DATA_W-1:0]  rdata,
  input  wire logic                        core_deep_sleep,
  input  wire logic                        core_in_handler,
  input  wire logic [PRIO_W-1:0]           handler_prio,
  input  wire logic                        intc_wake_req,
  input  wire logic [PRIO_W-1:0]           wake_prio,
  input  wire logic [N_WAKE-1:0]           hib_wake_pin,
  input  wire logic                        debug_hold_set,
  input  wire logic [N_PERIPH-1:0]         periph_user_off,
  output logic      [1:0]                  power_mode,
  output logic                             core_clk_en,
  output logic                             sys_bus_clk_en,
  output logic                             periph_bus_clk_en,
  output logic      [N_PERIPH-1:0]         periph_clk_en,
  output logic                             intc_clk_en,
  output logic                             logic_power_en,
  output logic                             retention_en,
  output logic                             wake_pulse
);
  import pwr_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (N_PERIPH < 1 || N_PERIPH > REG_W) begin : g_bad_periph
    $error("N_PERIPH out of range");
  end
  if (N_WAKE < 1 || PRIO_W < 1) begin : g_bad_wake
    $error("N_WAKE and PRIO_W must be positive");
  end

  // ==========================================================
  // Declarations
  logic              warm_rst;
  logic              mode_hit;
  logic              key_hit;
  logic              stat_hit;
  logic              unlocked;
  logic [1:0]        mode_sel_r;
  logic [15:0]       key_val_r;
  logic              debug_hold_r;
  logic              entered_in_handler_r;
  logic [PRIO_W-1:0] entry_prio_r;
  pwr_mode_t         state_r;
  pwr_mode_t         state_nxt;
  logic [N_WAKE-1:0] pin_level;
  logic              enter_ok;
  logic              prio_ok;
  logic              intc_wake;
  logic              pin_wake;
  logic              wake_ok;

  assign warm_rst = srst | sys_rst;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  assign mode_hit = hit(addr, MODE_ADDR);
  assign key_hit  = hit(addr, KEY_ADDR);
  assign stat_hit = hit(addr, STAT_ADDR);

  // ==========================================================
  // Sub-blocks
  key_unlock u_key (
    .core_clk (core_clk),
    .srst     (warm_rst),
    .wr_stb   (wr_stb),
    .key_hit  (key_hit),
    .mode_hit (mode_hit),
    .wdata    (wdata[15:0]),
    .unlocked (unlocked)
  );

  // Pins are asynchronous to the always-on clock
  wake_sync #(
    .W (N_WAKE)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .pin_in   (hib_wake_pin),
    .level    (pin_level)
  );

  // ==========================================================
  // Registers
  // two-bit field, reads back last write
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      mode_sel_r <= MODE_RST;
    end else if (wr_stb && mode_hit && unlocked) begin
      mode_sel_r <= wdata[1:0];
    end
  end

  // key register holds last key word
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      key_val_r <= KEY_RST;
    end else if (wr_stb && key_hit) begin
      key_val_r <= wdata[15:0];
    end
  end

  // cleared only by power-on reset, not warm reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      debug_hold_r <= 1'b0;
    end else if (debug_hold_set) begin
      debug_hold_r <= 1'b1;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      rdata <= '0;
    end else if (rd_stb && mode_hit) begin
      rdata <= {{(DATA_W - 2){1'b0}}, mode_sel_r};
    end else if (rd_stb && key_hit) begin
      rdata <= {{(DATA_W - REG_W){1'b0}}, key_val_r};
    end else if (rd_stb && stat_hit) begin
      rdata                   <= '0;
      rdata[STAT_STATE_LSB+:2] <= state_r;
      rdata[STAT_UNLOCK]      <= unlocked;
      rdata[STAT_DBG_HOLD]    <= debug_hold_r;
      rdata[STAT_HANDLER]     <= entered_in_handler_r;
    end else begin
      rdata <= '0;
    end
  end

  // ==========================================================
  // Entry and wake qualification
  // leave active only on deep sleep
  // mode 0 keeps the unit active on core sleep
  // debug hold keeps the unit active
  assign enter_ok = core_deep_sleep && (mode_sel_r != ST_ACTIVE) && !debug_hold_r;

  // in-handler entry needs a strictly more urgent wake
  assign prio_ok = !entered_in_handler_r || (wake_prio < entry_prio_r);

  assign intc_wake = intc_wake_req && prio_ok;

  // only the fixed pin set wakes hibernate
  assign pin_wake = |(pin_level & HIB_WAKE_MASK) && prio_ok;

  always_comb begin
    unique case (state_r)
      ST_CORE_SLEEP: wake_ok = intc_wake;
      ST_SYSTEM_SLEEP:  wake_ok = intc_wake;
      ST_HIBERNATE:  wake_ok = pin_wake;
      ST_ACTIVE:     wake_ok = 1'b0;
    endcase
  end

  // Handler context captured at entry; controller clock stops in hibernate
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      entered_in_handler_r <= 1'b0;
      entry_prio_r         <= '0;
    end else if (state_r == ST_ACTIVE && enter_ok) begin
      entered_in_handler_r <= core_in_handler;
      entry_prio_r         <= handler_prio;
    end
  end

  // ==========================================================
  // Mode state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ACTIVE: begin
        if (enter_ok) begin
          state_nxt = pwr_mode_t'(mode_sel_r);
        end
      end
      ST_CORE_SLEEP, ST_SYSTEM_SLEEP, ST_HIBERNATE: begin
        if (wake_ok) begin
          state_nxt = ST_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      state_r <= ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Gating outputs, one cycle behind the state
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      power_mode <= ST_ACTIVE;
      wake_pulse <= 1'b0;
    end else begin
      power_mode <= state_r;
      wake_pulse <= (state_r != ST_ACTIVE) && wake_ok;
    end
  end

  // core clock off in every low power state
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      core_clk_en <= 1'b1;
    end else begin
      core_clk_en <= (state_r == ST_ACTIVE);
    end
  end

  // buses run in mode 1 so DMA continues
  // mode 2 and beyond stop both buses
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      sys_bus_clk_en    <= 1'b1;
      periph_bus_clk_en <= 1'b1;
    end else begin
      sys_bus_clk_en    <= (state_r == ST_ACTIVE) || (state_r == ST_CORE_SLEEP);
      periph_bus_clk_en <= (state_r == ST_ACTIVE) || (state_r == ST_CORE_SLEEP);
    end
  end

  // user gating ignored in mode 2 and 3
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      periph_clk_en <= '1;
    end else if (state_r == ST_ACTIVE || state_r == ST_CORE_SLEEP) begin
      periph_clk_en <= ~periph_user_off;
    end else begin
      periph_clk_en <= '0;
    end
  end

  // controller clock runs except in hibernate
  // hibernate removes logic power and retains flops
  always_ff @(posedge core_clk) begin
    if (warm_rst) begin
      intc_clk_en    <= 1'b1;
      logic_power_en <= 1'b1;
      retention_en   <= 1'b0;
    end else begin
      intc_clk_en    <= (state_r != ST_HIBERNATE);
      logic_power_en <= (state_r != ST_HIBERNATE);
      retention_en   <= (state_r == ST_HIBERNATE);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (warm_rst);

  chk_enter_selected: assert property (
    (state_r == ST_ACTIVE && enter_ok) |=> state_r == pwr_mode_t'($past(mode_sel_r)))
    else $error("entered mode differs from selection");

  chk_active_stays: assert property (
    (state_r == ST_ACTIVE && mode_sel_r == 2'h0) |=> state_r == ST_ACTIVE)
    else $error("left active with mode 0 selected");
  // wake returns to active and pulses
  chk_wake_active: assert property (
    (state_r != ST_ACTIVE && wake_ok) |=> (state_r == ST_ACTIVE && wake_pulse) ##1 (core_clk_en && !wake_pulse))
    else $error("wake did not restore active");
  chk_core_gate: assert property (
    state_r == ST_CORE_SLEEP |=> !core_clk_en && sys_bus_clk_en && periph_bus_clk_en)
    else $error("mode 1 gating wrong");

  // controller clock alive in modes 1 and 2
  chk_intc_clock: assert property (
    (state_r == ST_CORE_SLEEP || state_r == ST_SYSTEM_SLEEP) |=> intc_clk_en)
    else $error("controller clock stopped in mode 1 or 2");

  chk_bus_gate: assert property (
    state_r == ST_SYSTEM_SLEEP |=> !sys_bus_clk_en && !periph_bus_clk_en && !core_clk_en)
    else $error("mode 2 buses not gated");

  chk_periph_forced: assert property (
    (state_r == ST_SYSTEM_SLEEP || state_r == ST_HIBERNATE) |=> periph_clk_en == '0)
    else $error("peripheral clock on in mode 2 or 3");

  chk_hib_power: assert property (
    state_r == ST_HIBERNATE |=> !logic_power_en && retention_en && !intc_clk_en)
    else $error("hibernate power controls wrong");

  chk_hib_ignore: assert property (
    (state_r == ST_HIBERNATE && !pin_wake) |=> state_r == ST_HIBERNATE)
    else $error("hibernate left without pin wake");
  chk_handler_prio: assert property (
    (state_r == ST_CORE_SLEEP && entered_in_handler_r && wake_prio >= entry_prio_r)
      |=> state_r == ST_CORE_SLEEP)
    else $error("woke on low priority after handler entry");

  chk_debug_block: assert property (
    (state_r == ST_ACTIVE && debug_hold_r) |=> state_r == ST_ACTIVE [*2])
    else $error("entered low power under debug hold");

  chk_key_gate: assert property (
    (wr_stb && mode_hit && !unlocked) |=> $stable(mode_sel_r))
    else $error("mode written while locked");

  chk_mode_read: assert property (
    (rd_stb && mode_hit) |=> rdata == {30'h0, $past(mode_sel_r)})
    else $error("mode readback wrong");
  chk_deep_entry: assert property (
    (state_r == ST_ACTIVE && !core_deep_sleep) |=> state_r == ST_ACTIVE)
    else $error("left active without deep sleep");

  cov_core_sleep: cover property (state_r == ST_ACTIVE ##1 state_r == ST_CORE_SLEEP ##[1:20] state_r == ST_ACTIVE);
  cov_system_sleep:  cover property (state_r == ST_SYSTEM_SLEEP ##1 wake_ok);
  cov_hibernate:  cover property (state_r == ST_HIBERNATE && pin_wake);
  cov_unlock:     cover property (wr_stb && mode_hit && unlocked);
endmodule
`default_nettype wire

// >>> design/pwr_pkg.sv
// Shared constants and types of the power mode controller
package pwr_pkg;

  // ==========================================================
  // Bus and register map
  localparam int          ADDR_W     = 32;
  localparam int          DATA_W     = 32;
  localparam int          REG_W      = 16;
  localparam logic [31:0] MODE_ADDR  = 32'h4000_2400;
  localparam logic [31:0] KEY_ADDR   = 32'h4000_2404;
  localparam logic [31:0] STAT_ADDR  = 32'h4000_2408;

  // ==========================================================
  // Reset values and key words
  localparam logic [1:0]  MODE_RST   = 2'h0;
  localparam logic [15:0] KEY_RST    = 16'h0000;
  localparam logic [15:0] KEY_FIRST  = 16'h4859;
  localparam logic [15:0] KEY_SECOND = 16'hF27B;

  // ==========================================================
  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_UNLOCK    = 2;
  localparam int STAT_DBG_HOLD  = 3;
  localparam int STAT_HANDLER   = 4;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_ACTIVE     = 2'b00,
    ST_CORE_SLEEP = 2'b01,
    ST_SYSTEM_SLEEP  = 2'b10,
    ST_HIBERNATE  = 2'b11
  } pwr_mode_t;

  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF   = 2'b01,
    KEY_OPEN   = 2'b10
  } key_state_t;

endpackage

// >>> design/wake_sync.sv
// Three-stage synchroniser with agreement filter for wake pins
`timescale 1ns/1ns
`default_nettype none
module wake_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ==========================================================
  // Stages; only the second stage reads the first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Bitwise: a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      level <= '0;
    end else begin
      level <= (s2_r & s3_r) | (level & (s2_r | s3_r));
    end
  end

endmodule
`default_nettype wire

// >>> design/key_unlock.sv
// Two-word unlock sequencer guarding the mode register
`timescale 1ns/1ns
`default_nettype none
module key_unlock (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        wr_stb,
  input  wire logic        key_hit,
  input  wire logic        mode_hit,
  input  wire logic [15:0] wdata,
  output logic             unlocked
);
  import pwr_pkg::*;

  key_state_t state_r;
  key_state_t state_nxt;

  // ==========================================================
  // Sequence
  always_comb begin
    state_nxt = state_r;
    if (wr_stb) begin
      unique case (state_r)
        KEY_LOCKED: begin
          state_nxt = (key_hit && wdata == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
        end
        KEY_HALF: begin
          // Wrong second word restarts, but may itself be a first word
          if (key_hit && wdata == KEY_SECOND) begin
            state_nxt = KEY_OPEN;
          end else if (key_hit && wdata == KEY_FIRST) begin
            state_nxt = KEY_HALF;
          end else begin
            state_nxt = KEY_LOCKED;
          end
        end
        KEY_OPEN: begin
          state_nxt = KEY_LOCKED;
        end
        default: begin
          state_nxt = KEY_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= KEY_LOCKED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign unlocked = (state_r == KEY_OPEN);

  // ==========================================================
  // Checks
  // relock on stray write
  chk_key_relock: assert property (@(posedge core_clk) disable iff (srst)
    (state_r == KEY_OPEN && wr_stb && !mode_hit) |=> state_r == KEY_LOCKED)
    else $error("key not relocked after other write");

endmodule
`default_nettype wire

// >>> tb/core_model.sv
// Behavioural processor core and interrupt controller facing the power unit
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [1:0] power_mode,
  input  wire logic [3:0] hib_wake_pin,
  input  wire logic       core_in_handler,
  input  wire logic [7:0] handler_prio,
  input  wire logic       sleep_go,
  input  wire logic       irq_go,
  input  wire logic [7:0] irq_prio,
  output logic            core_deep_sleep,
  output logic            intc_wake_req,
  output logic [7:0]      wake_prio
);
  logic [2:0] irq_cnt_r;

  // ==========================================================
  // Deep sleep level
  // Dropped together with the wake cause, else the unit would re-enter sleep
  always_ff @(posedge core_clk) begin
    if (srst) begin
      core_deep_sleep <= 1'b0;
    end else if (sleep_go) begin
      core_deep_sleep <= 1'b1;
    // no interrupt clock in hibernate, pins only
    end else if (power_mode == 2'h3) begin
      if (|hib_wake_pin) begin
        core_deep_sleep <= 1'b0;
      end
    // inside a handler only a more urgent interrupt wakes the core
    end else if (irq_go && (!core_in_handler || irq_prio < handler_prio)) begin
      core_deep_sleep <= 1'b0;
    end
  end

  // ==========================================================
  // Wake request, held five cycles
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_cnt_r     <= 3'h0;
      intc_wake_req <= 1'b0;
      wake_prio     <= 8'h00;
    end else if (irq_go) begin
      irq_cnt_r     <= 3'h4;
      intc_wake_req <= 1'b1;
      wake_prio     <= irq_prio;
    end else if (irq_cnt_r != 3'h0) begin
      irq_cnt_r <= irq_cnt_r - 3'h1;
    end else begin
      intc_wake_req <= 1'b0;
      // Released priority lines toggle so stale values never look valid
      wake_prio     <= ~wake_prio;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the power mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pwr_pkg::*;
  logic        core_clk, srst, sys_rst, wr_stb, rd_stb, core_deep_sleep, core_in_handler;
  logic [31:0] addr, wdata, rdata;
  logic [7:0]  handler_prio, wake_prio, irq_prio;
  logic        intc_wake_req, debug_hold_set, sleep_go, irq_go, wake_pulse;
  logic [3:0]  hib_wake_pin;
  logic [4:0]  periph_user_off, periph_clk_en;
  logic [1:0]  power_mode;
  logic        core_clk_en, sys_bus_clk_en, periph_bus_clk_en, intc_clk_en, logic_power_en, retention_en;
  int          n_mismatch, n_tests;
  int          mode_exp;
  int          key_q[$];
  logic        key_open;

  power_mode_controller power_mode_controller_inst (.core_clk(core_clk), .srst(srst), .sys_rst(sys_rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .core_deep_sleep(core_deep_sleep), .core_in_handler(core_in_handler), .handler_prio(handler_prio),
    .intc_wake_req(intc_wake_req), .wake_prio(wake_prio), .hib_wake_pin(hib_wake_pin),
    .debug_hold_set(debug_hold_set), .periph_user_off(periph_user_off), .power_mode(power_mode),
    .core_clk_en(core_clk_en), .sys_bus_clk_en(sys_bus_clk_en), .periph_bus_clk_en(periph_bus_clk_en),
    .periph_clk_en(periph_clk_en), .intc_clk_en(intc_clk_en), .logic_power_en(logic_power_en),
    .retention_en(retention_en), .wake_pulse(wake_pulse));

  core_model core_model_inst (.core_clk(core_clk), .srst(srst), .power_mode(power_mode),
    .hib_wake_pin(hib_wake_pin), .core_in_handler(core_in_handler), .handler_prio(handler_prio),
    .sleep_go(sleep_go), .irq_go(irq_go), .irq_prio(irq_prio), .core_deep_sleep(core_deep_sleep),
    .intc_wake_req(intc_wake_req), .wake_prio(wake_prio));

  // ==========================================================
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // Compare, verdict and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    // key model; a full key opens exactly one write
    if (key_open && a == MODE_ADDR) begin
      mode_exp = int'(d[1:0]);
    end
    if (a == KEY_ADDR && !key_open) begin
      key_q.push_back(int'(d[15:0]));
    end else begin
      key_q.delete();
    end
    key_open = (key_q.size() >= 2) && (key_q[$-1] == int'(KEY_FIRST)) && (key_q[$] == int'(KEY_SECOND));
    if (key_open) begin
      key_q.delete();
    end
  endtask

  task automatic model_reset();
    mode_exp = 0;
    key_open = 1'b0;
    key_q.delete();
  endtask

  task automatic idle();
    @(posedge core_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    idle();
    #1;
    check(rdata, exp);
    if (a == MODE_ADDR) begin
      check(rdata, 32'(mode_exp));
    end
  endtask

  task automatic unlock_write(input logic [31:0] m);
    wr(KEY_ADDR, 32'(KEY_FIRST));
    wr(KEY_ADDR, 32'(KEY_SECOND));
    wr(MODE_ADDR, m);
    idle();
  endtask

  // Expected pin picture of a mode, from the mode table
  task automatic chk_out(input logic [1:0] m);
    logic [4:0] pe;
    pe = (m < 2'h2) ? ~periph_user_off : 5'h00;
    check(32'({power_mode, core_clk_en, sys_bus_clk_en, periph_bus_clk_en, periph_clk_en, intc_clk_en,
      logic_power_en, retention_en}), 32'({m, m == 2'h0, m < 2'h2, m < 2'h2, pe, m != 2'h3, m != 2'h3,
      m == 2'h3}));
  endtask

  task automatic go_sleep();
    @(posedge core_clk);
    sleep_go <= 1'b1;
    @(posedge core_clk);
    sleep_go <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic irq(input logic [7:0] p);
    @(posedge core_clk);
    irq_go   <= 1'b1;
    irq_prio <= p;
    @(posedge core_clk);
    irq_go <= 1'b0;
  endtask

  // Bounded wait for the wake pulse, then back in active
  task automatic wait_wake();
    for (int i = 0; i < 30 && wake_pulse !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    check(32'(wake_pulse), 32'h1);
    // Pulse comes with the state; the pin picture follows one cycle later
    @(posedge core_clk);
    #1;
    check(32'(wake_pulse), 32'h0);
    chk_out(2'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {srst, sys_rst, wr_stb, rd_stb, core_in_handler, debug_hold_set, sleep_go, irq_go} = 8'hFF;
    {sys_rst, wr_stb, rd_stb, core_in_handler, debug_hold_set, sleep_go, irq_go} = 7'h00;
    {addr, wdata, handler_prio, irq_prio, hib_wake_pin, periph_user_off} = '0;
    n_mismatch = 0;
    n_tests = 0;
    model_reset();
    void'($urandom(32'h49E38637));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_out(2'h0);
    rd_chk(MODE_ADDR, 32'h0);
    rd_chk(KEY_ADDR, 32'h0);
    rd_chk(32'h4000_2410, 32'h0);
    wr(MODE_ADDR, 32'h2);
    idle();
    rd_chk(MODE_ADDR, 32'h0);
    go_sleep();
    chk_out(2'h0);
    irq(8'h00);
    repeat (3) @(posedge core_clk);
    // Every low power mode, in and out
    for (int m = 1; m < 4; m++) begin
      @(posedge core_clk);
      periph_user_off <= 5'($urandom);
      unlock_write(32'(m));
      rd_chk(MODE_ADDR, 32'(m));
      chk_out(2'h0);
      go_sleep();
      chk_out(2'(m));
      @(posedge core_clk);
      periph_user_off <= ~periph_user_off;
      @(posedge core_clk);
      #1;
      chk_out(2'(m));
      if (m == 3) begin
        irq(8'h00);
        repeat (6) @(posedge core_clk);
        #1;
        chk_out(2'h3);
        @(posedge core_clk);
        hib_wake_pin <= 4'h1;
      end else begin
        irq(8'h20);
      end
      wait_wake();
      @(posedge core_clk);
      hib_wake_pin <= 4'h0;
      rd_chk(MODE_ADDR, 32'(m));
    end
    // Key relocking
    wr(KEY_ADDR, 32'(KEY_FIRST));
    wr(KEY_ADDR, 32'(KEY_SECOND));
    wr(32'h4000_2410, 32'h0);
    wr(MODE_ADDR, 32'h1);
    idle();
    rd_chk(MODE_ADDR, 32'h3);
    wr(KEY_ADDR, 32'(KEY_FIRST));
    wr(KEY_ADDR, 32'h1234);
    wr(MODE_ADDR, 32'h1);
    idle();
    rd_chk(MODE_ADDR, 32'h3);
    wr(KEY_ADDR, 32'(KEY_FIRST));
    unlock_write(32'h0);
    rd_chk(MODE_ADDR, 32'h0);
    rd_chk(KEY_ADDR, 32'(KEY_SECOND));
    // Sleep entered inside a handler
    unlock_write(32'h1);
    @(posedge core_clk);
    core_in_handler <= 1'b1;
    handler_prio    <= 8'h10;
    go_sleep();
    irq(8'h10);
    repeat (8) @(posedge core_clk);
    #1;
    chk_out(2'h1);
    irq(8'h05);
    wait_wake();
    @(posedge core_clk);
    core_in_handler <= 1'b0;
    // Debug hold survives warm reset, cleared at power-on
    debug_hold_set <= 1'b1;
    @(posedge core_clk);
    debug_hold_set <= 1'b0;
    sys_rst        <= 1'b1;
    model_reset();
    @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(STAT_ADDR, 32'h8);
    unlock_write(32'h1);
    go_sleep();
    chk_out(2'h0);
    irq(8'h00);
    @(posedge core_clk);
    srst <= 1'b1;
    model_reset();
    @(posedge core_clk);
    srst <= 1'b0;
    unlock_write(32'h2);
    go_sleep();
    chk_out(2'h2);
    irq(8'h20);
    wait_wake();
    print_verdict();
  end
endmodule
`default_nettype wire
